// ### hw/vcs_consts.svh
/*
 * constants of the vco calibration sequencer: register byte offsets,
 * field positions, widths, reset values and phase timing counts.
 * assumes inclusion by the package and by the design modules.
 */
`ifndef VCS_CONSTS_SVH
`define VCS_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define VCS_OFF_INTEGER     8'h00
`define VCS_OFF_PFRAC       8'h04
`define VCS_OFF_AFRAC       8'h08
`define VCS_OFF_AMOD        8'h0C
`define VCS_OFF_REFCTL      8'h10
`define VCS_OFF_CALTIME     8'h14
`define VCS_OFF_BANDDIV     8'h18
`define VCS_OFF_STATUS      8'h1C

// ----------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------
`define VCS_REF_DOUBLER     0
`define VCS_REF_HALVE       1
`define VCS_REF_RCNT_LSB    2
`define VCS_CT_TIMEOUT_LSB  0
`define VCS_CT_SETTLE_LSB   10
`define VCS_CT_WAIT_LSB     15
`define VCS_INT_W           16
`define VCS_PFRAC_W         24
`define VCS_AFRAC_W         28
`define VCS_RCNT_W          10
`define VCS_TIMEOUT_W       10
`define VCS_FIELD5_W        5
`define VCS_BDIV_W          8
`define VCS_COUNT_W         20
`define VCS_BPER_W          12

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define VCS_RST_RCNT        10'h001
`define VCS_RST_TIMEOUT     10'h001
`define VCS_RST_FIELD5      5'h01
`define VCS_RST_BDIV        8'h01
`define VCS_RST_AMOD        28'h000_0001

// ----------------------------------------------------------------------
// phase timing counts
// ----------------------------------------------------------------------
`define VCS_BAND_PRESCALE   12'h010
`define VCS_BAND_LAST       4'ha
`define VCS_LEVEL_MULT      20'h0_001e

`endif

// ### hw/vcs_pkg.sv
/*
 * types of the vco calibration sequencer: phase enumeration and the
 * packed state records of the sequencer core and the reference path.
 * assumes vcs_consts.svh is on the include path.
 */
package vcs_pkg;
`include "vcs_consts.svh"

    typedef enum logic [1:0] {
        VCS_IDLE,
        VCS_SETTLE,
        VCS_BAND,
        VCS_LEVEL
    } vcs_phase_t;

    typedef struct packed {
        vcs_phase_t                  phase;
        logic [`VCS_COUNT_W-1:0]     count;
        logic [`VCS_BPER_W-1:0]      divcnt;
        logic [3:0]                  bcycles;
        logic                        band_clk;
        logic [`VCS_INT_W-1:0]       integer_value;
        logic [`VCS_PFRAC_W-1:0]     primary_fraction;
        logic [`VCS_AFRAC_W-1:0]     aux_fraction;
        logic [`VCS_AFRAC_W-1:0]     aux_modulus;
        logic                        doubler;
        logic                        halve;
        logic [`VCS_RCNT_W-1:0]      ref_count;
        logic [`VCS_TIMEOUT_W-1:0]   timeout;
        logic [`VCS_FIELD5_W-1:0]    lock_settle;
        logic [`VCS_FIELD5_W-1:0]    level_cal_wait;
        logic [`VCS_BDIV_W-1:0]      band_select_divider;
        logic [`VCS_INT_W-1:0]       act_integer;
        logic [`VCS_PFRAC_W-1:0]     act_pfrac;
        logic [`VCS_AFRAC_W-1:0]     act_afrac;
        logic [`VCS_AFRAC_W-1:0]     act_amod;
        logic                        wr_pend;
        logic [7:0]                  wr_addr;
        logic [31:0]                 hrdata;
    } vcs_core_t;

    typedef struct packed {
        logic                        ref_q;
        logic [`VCS_RCNT_W-1:0]      rcnt;
        logic                        half;
        logic                        pd_tick;
        logic                        pd_clk;
    } vcs_ref_t;

endpackage

// ### hw/vcs_ref_path.sv
/*
 * reference path: optional doubler, reference counter and optional
 * divide by two, producing the phase detector tick and clock level.
 * assumes ref_in is a level synchronous to clk and much slower than it.
 */
`timescale 1ns/1ns
`include "vcs_consts.svh"

module vcs_ref_path
(
    input  wire logic                   clk,       // system clock
    input  wire logic                   reset_n,   // sync reset, low
    input  wire logic                   ce,        // clock enable
    input  wire logic                   ref_in,    // reference level
    input  wire logic                   doubler,   // use both edges
    input  wire logic                   halve,     // extra divide by 2
    input  wire logic [`VCS_RCNT_W-1:0] ref_count, // reference divider
    output logic                        pd_tick,   // one tick per cycle
    output logic                        pd_clk     // phase detector clock
);
    import vcs_pkg::*;

    vcs_ref_t                 s;
    vcs_ref_t                 n;
    logic                     src_tick;
    logic                     div_tick;
    logic [`VCS_RCNT_W-1:0]   rdiv;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        n        = s;
        div_tick = 1'b0;
        // both edges count when doubling
        src_tick = doubler ? (ref_in ^ s.ref_q)
                           : (ref_in & ~s.ref_q);
        rdiv     = (ref_count == '0) ? `VCS_RST_RCNT : ref_count;
        n.ref_q   = ref_in;
        n.pd_tick = 1'b0;
        if (src_tick)
        begin
            if (s.rcnt >= rdiv - `VCS_RST_RCNT)
            begin
                n.rcnt   = '0;
                div_tick = 1'b1;
            end
            else
            begin
                n.rcnt = s.rcnt + `VCS_RST_RCNT;
            end
        end
        if (div_tick)
        begin
            if (halve)
            begin
                n.half    = ~s.half;
                n.pd_tick = ~s.half;
            end
            else
            begin
                n.pd_tick = 1'b1;
            end
        end
        n.pd_clk = halve ? n.half : n.pd_tick;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            s <= '0;
        else if (ce)
            s <= n;
    end

    assign pd_tick = s.pd_tick;
    assign pd_clk  = s.pd_clk;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n || !ce);

    both_edges_a: assert property (
        (doubler && !halve && rdiv == `VCS_RST_RCNT && ref_in != s.ref_q)
        |=> pd_tick)
        else $error("doubled reference edge gave no tick");

    fall_ignored_a: assert property (
        (!doubler && !halve && !ref_in && s.ref_q) |=> !pd_tick)
        else $error("falling edge ticked without doubler");

    halve_rate_a: assert property (
        (halve && div_tick && s.half) |=> !pd_tick)
        else $error("halving stage ticked on both toggles");

    halve_duty_a: assert property (
        (halve && $stable(halve) && div_tick) |=> pd_clk != $past(pd_clk))
        else $error("halved clock did not toggle");

    divide_a: assert property (
        (src_tick && !halve && s.rcnt < rdiv - `VCS_RST_RCNT) |=> !pd_tick)
        else $error("reference counter ticked early");

endmodule

// ### hw/vcs_cal_sequencer.sv
/*
 * vco calibration sequencer with its register file on ahb-lite.
 * holds frequency words, reference path settings and calibration timing,
 * and runs settle, band selection and level calibration phases counted
 * in phase detector cycles. assumes a single ahb-lite master, word
 * transfers, ref_in synchronous to clk.
 */
`timescale 1ns/1ns
`include "vcs_consts.svh"

module vcs_cal_sequencer
(
    input  wire logic                    clk,            // 100 MHz clock
    input  wire logic                    reset_n,        // sync reset, low
    input  wire logic                    ce,             // clock enable
    input  wire logic                    hsel,           // slave select
    input  wire logic [31:0]             haddr,          // byte address
    input  wire logic [1:0]              htrans,         // transfer type
    input  wire logic                    hwrite,         // write when high
    input  wire logic [2:0]              hsize,          // transfer size
    input  wire logic [31:0]             hwdata,         // write data
    input  wire logic                    hready,         // bus ready
    output logic                         hreadyout,      // slave ready
    output logic                         hresp,          // always okay
    output logic [31:0]                  hrdata,         // read data
    input  wire logic                    ref_in,         // reference level
    output logic                         phase_detector_clock, // pd clock
    output logic                         dac_force,      // settle phase
    output logic                         band_select_active, // band phase
    output logic                         band_select_clock, // band pulse
    output logic                         level_calibration_active, // level
    output logic                         cal_busy,       // any phase
    output logic [`VCS_INT_W-1:0]        active_integer, // applied integer
    output logic [`VCS_PFRAC_W-1:0]      active_primary_fraction, // frac
    output logic [`VCS_AFRAC_W-1:0]      active_aux_fraction, // aux frac
    output logic [`VCS_AFRAC_W-1:0]      active_aux_modulus // aux modulus
);
    import vcs_pkg::*;

    localparam vcs_core_t CORE_RESET = '{
        phase:               VCS_IDLE,
        ref_count:           `VCS_RST_RCNT,
        timeout:             `VCS_RST_TIMEOUT,
        lock_settle:         `VCS_RST_FIELD5,
        level_cal_wait:      `VCS_RST_FIELD5,
        band_select_divider: `VCS_RST_BDIV,
        aux_modulus:         `VCS_RST_AMOD,
        act_amod:            `VCS_RST_AMOD,
        default:             '0
    };

    vcs_core_t               s;
    vcs_core_t               n;
    logic                    pd_tick;
    logic                    int_write;
    logic [`VCS_BPER_W-1:0]  bper;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [`VCS_COUNT_W-1:0] at_least_one
    (
        input logic [`VCS_COUNT_W-1:0] v
    );
        at_least_one = (v == '0) ? `VCS_COUNT_W'(1) : v;
    endfunction

    function automatic logic [`VCS_COUNT_W-1:0] settle_count
    (
        input logic [`VCS_TIMEOUT_W-1:0] t,
        input logic [`VCS_FIELD5_W-1:0]  l
    );
        settle_count = at_least_one(`VCS_COUNT_W'(t) * `VCS_COUNT_W'(l));
    endfunction

    function automatic logic [`VCS_COUNT_W-1:0] level_count
    (
        input logic [`VCS_FIELD5_W-1:0]  w,
        input logic [`VCS_TIMEOUT_W-1:0] t
    );
        level_count = at_least_one(`VCS_LEVEL_MULT * `VCS_COUNT_W'(w)
                                   * `VCS_COUNT_W'(t));
    endfunction

    function automatic logic [`VCS_BPER_W-1:0] band_period
    (
        input logic [`VCS_BDIV_W-1:0] d
    );
        logic [`VCS_BDIV_W-1:0] b;
        b = (d == '0) ? `VCS_RST_BDIV : d;
        band_period = `VCS_BAND_PRESCALE * {4'h0, b};
    endfunction

    function automatic logic [31:0] rd_word
    (
        input logic [7:0] a
    );
        rd_word = 32'h0000_0000;
        case (a)
            `VCS_OFF_INTEGER: rd_word = {16'h0000, s.integer_value};
            `VCS_OFF_PFRAC:   rd_word = {8'h00, s.primary_fraction};
            `VCS_OFF_AFRAC:   rd_word = {4'h0, s.aux_fraction};
            `VCS_OFF_AMOD:    rd_word = {4'h0, s.aux_modulus};
            `VCS_OFF_REFCTL:  rd_word = {20'h0_0000, s.ref_count,
                                         s.halve, s.doubler};
            `VCS_OFF_CALTIME: rd_word = {12'h000, s.level_cal_wait,
                                         s.lock_settle, s.timeout};
            `VCS_OFF_BANDDIV: rd_word = {24'h00_0000, s.band_select_divider};
            `VCS_OFF_STATUS:  rd_word = {25'h000_0000, s.bcycles, s.phase,
                                         s.phase != VCS_IDLE};
            default:          rd_word = 32'h0000_0000;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // reference path
    // ------------------------------------------------------------------
    vcs_ref_path u_ref
    (
        .clk       (clk),
        .reset_n   (reset_n),
        .ce        (ce),
        .ref_in    (ref_in),
        .doubler   (s.doubler),
        .halve     (s.halve),
        .ref_count (s.ref_count),
        .pd_tick   (pd_tick),
        .pd_clk    (phase_detector_clock)
    );

    assign int_write = s.wr_pend && (s.wr_addr == `VCS_OFF_INTEGER);
    assign bper      = band_period(s.band_select_divider);

    // ------------------------------------------------------------------
    // bus slave and sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        n          = s;
        n.band_clk = 1'b0;
        n.wr_pend  = 1'b0;
        if (hsel && htrans[1] && hready)
        begin
            n.wr_pend = hwrite && (hsize == 3'b010);
            n.wr_addr = haddr[7:0];
            if (!hwrite)
                n.hrdata = rd_word(haddr[7:0]);
        end
        if (s.wr_pend)
        begin
            case (s.wr_addr)
                `VCS_OFF_INTEGER: n.integer_value = hwdata[`VCS_INT_W-1:0];
                `VCS_OFF_PFRAC:   n.primary_fraction =
                                      hwdata[`VCS_PFRAC_W-1:0];
                `VCS_OFF_AFRAC:   n.aux_fraction = hwdata[`VCS_AFRAC_W-1:0];
                `VCS_OFF_AMOD:    n.aux_modulus = hwdata[`VCS_AFRAC_W-1:0];
                `VCS_OFF_REFCTL:
                begin
                    n.doubler   = hwdata[`VCS_REF_DOUBLER];
                    n.halve     = hwdata[`VCS_REF_HALVE];
                    n.ref_count = hwdata[`VCS_REF_RCNT_LSB +: `VCS_RCNT_W];
                end
                `VCS_OFF_CALTIME:
                begin
                    n.timeout = hwdata[`VCS_CT_TIMEOUT_LSB +: `VCS_TIMEOUT_W];
                    n.lock_settle =
                        hwdata[`VCS_CT_SETTLE_LSB +: `VCS_FIELD5_W];
                    n.level_cal_wait =
                        hwdata[`VCS_CT_WAIT_LSB +: `VCS_FIELD5_W];
                end
                `VCS_OFF_BANDDIV:
                    n.band_select_divider = hwdata[`VCS_BDIV_W-1:0];
                default:
                    n.wr_addr = s.wr_addr;
            endcase
        end
        if (int_write)
        begin
            // integer plus fraction words applied as one set
            n.act_integer = hwdata[`VCS_INT_W-1:0];
            n.act_pfrac   = s.primary_fraction;
            n.act_afrac   = s.aux_fraction;
            n.act_amod    = s.aux_modulus;
            n.phase       = VCS_SETTLE;
            n.count       = settle_count(s.timeout, s.lock_settle);
        end
        else if (pd_tick)
        begin
            case (s.phase)
                VCS_SETTLE:
                begin
                    if (s.count == `VCS_COUNT_W'(1))
                    begin
                        n.phase   = VCS_BAND;
                        n.divcnt  = '0;
                        n.bcycles = '0;
                    end
                    else
                    begin
                        n.count = s.count - `VCS_COUNT_W'(1);
                    end
                end
                VCS_BAND:
                begin
                    if (s.divcnt >= bper - `VCS_BPER_W'(1))
                    begin
                        n.divcnt   = '0;
                        n.band_clk = 1'b1;
                        if (s.bcycles == `VCS_BAND_LAST)
                        begin
                            n.phase = VCS_LEVEL;
                            n.count = level_count(s.level_cal_wait,
                                                  s.timeout);
                        end
                        else
                        begin
                            n.bcycles = s.bcycles + 4'h1;
                        end
                    end
                    else
                    begin
                        n.divcnt = s.divcnt + `VCS_BPER_W'(1);
                    end
                end
                VCS_LEVEL:
                begin
                    if (s.count == `VCS_COUNT_W'(1))
                        n.phase = VCS_IDLE;
                    else
                        n.count = s.count - `VCS_COUNT_W'(1);
                end
                default:
                    n.phase = VCS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            s <= CORE_RESET;
        else if (ce)
            s <= n;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign hreadyout                = 1'b1;
    assign hresp                    = 1'b0;
    assign hrdata                   = s.hrdata;
    assign dac_force                = (s.phase == VCS_SETTLE);
    assign band_select_active       = (s.phase == VCS_BAND);
    assign band_select_clock        = s.band_clk;
    assign level_calibration_active = (s.phase == VCS_LEVEL);
    assign cal_busy                 = (s.phase != VCS_IDLE);
    assign active_integer           = s.act_integer;
    assign active_primary_fraction  = s.act_pfrac;
    assign active_aux_fraction      = s.act_afrac;
    assign active_aux_modulus       = s.act_amod;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [3:0] bclk_seen;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            bclk_seen <= 4'h0;
        else if (ce && s.phase != VCS_BAND)
            bclk_seen <= 4'h0;
        else if (ce && s.band_clk)
            bclk_seen <= bclk_seen + 4'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n || !ce);

    sequence settle_last_s;
        s.phase == VCS_SETTLE && s.count == `VCS_COUNT_W'(1)
            && pd_tick && !int_write;
    endsequence
    sequence enter_level_s;
        s.phase == VCS_LEVEL && $past(s.phase) == VCS_BAND;
    endsequence

    settle_load_a: assert property (
        int_write |=> s.phase == VCS_SETTLE
            && s.count == settle_count(s.timeout, s.lock_settle))
        else $error("settle phase loaded wrong count");
    settle_hold_a: assert property (
        (s.phase == VCS_SETTLE && s.count != `VCS_COUNT_W'(1)
            && !int_write) |=> s.phase == VCS_SETTLE)
        else $error("settle phase left before its count ran out");
    settle_done_a: assert property (
        settle_last_s |=> s.phase == VCS_BAND && s.bcycles == 4'h0)
        else $error("band selection did not follow settling");
    band_tick_a: assert property (
        (s.phase == VCS_BAND && pd_tick && !int_write
            && s.divcnt == bper - `VCS_BPER_W'(1)) |=> band_select_clock)
        else $error("band clock missed its divided tick");
    band_gap_a: assert property (
        band_select_clock |-> s.divcnt == '0 && !$past(band_select_clock))
        else $error("band clock pulse out of place");
    band_eleven_a: assert property (
        enter_level_s |-> band_select_clock && bclk_seen == 4'ha)
        else $error("band selection did not last eleven cycles");
    level_load_a: assert property (
        enter_level_s |-> s.count
            == level_count(s.level_cal_wait, s.timeout))
        else $error("level calibration loaded wrong count");
    level_done_a: assert property (
        (s.phase == VCS_LEVEL && s.count == `VCS_COUNT_W'(1) && pd_tick
            && !int_write) |=> s.phase == VCS_IDLE)
        else $error("sequencer did not return to idle");
    idle_stays_a: assert property (
        (s.phase == VCS_IDLE && !int_write) |=> s.phase == VCS_IDLE
            && $stable(active_integer))
        else $error("calibration started without integer write");

endmodule

// ### testbench/vcs_ref_src.sv
/* reference source: square wave of eight clk cycles on ref_in.
   assumes clk at 100 MHz and a synchronous active low reset. */
`timescale 1ns/1ns
module vcs_ref_src
(
    input  wire logic clk,     // system clock
    input  wire logic reset_n, // sync reset, low
    output logic      ref_in   // reference level
);
    logic [1:0] cnt;
    always_ff @(posedge clk)
    begin
        cnt    <= reset_n ? cnt + 2'h1 : 2'h0;
        ref_in <= !reset_n ? 1'b0 : (cnt == 2'h3) ? !ref_in : ref_in;
    end
endmodule

// ### testbench/testbench.sv
/* testbench: ahb-lite host tasks and calibration sequence checks.
   assumes vcs_consts.svh on the include path and vcs_ref_src. */
`timescale 1ns/1ns
`include "vcs_consts.svh"
module testbench;
    logic        clk = 0, reset_n = 0, hsel = 0, hwrite = 0, ref_in;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd, rdv;
    logic        hreadyout, hresp, pd, dacf, bact, bclk, lact, busy;
    logic [15:0] a_int;
    logic [23:0] a_pf;
    logic [27:0] a_am, a_af;
    logic [31:0] refv [4] = '{32'h0000_0004, 32'h0000_0005,
                              32'h0000_0008, 32'h0000_0006};
    int          ep [4] = '{8, 4, 16, 16};
    int          eh [4] = '{1, 1, 1, 8};
    int          n_fail = 0, compares = 0, cyc = 0, per, hi, n0, n1, n2, n3;
    always #5 clk = !clk;
    vcs_ref_src i_ref(.clk(clk), .reset_n(reset_n), .ref_in(ref_in));
    vcs_cal_sequencer i_dut(.clk(clk), .reset_n(reset_n), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(rd),
        .ref_in(ref_in), .phase_detector_clock(pd), .dac_force(dacf),
        .band_select_active(bact), .band_select_clock(bclk),
        .level_calibration_active(lact), .cal_busy(busy),
        .active_integer(a_int), .active_primary_fraction(a_pf),
        .active_aux_fraction(a_af), .active_aux_modulus(a_am));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rdv = rd;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(rdv, e);
    endtask
    // one full period of the detector clock, from rise to rise
    task meas;
        @(negedge clk);
        while (pd !== 1'b0) @(negedge clk);
        while (pd !== 1'b1) @(negedge clk);
        per = 0;
        hi = 0;
        do
        begin
            hi += (pd === 1'b1);
            per++;
            @(negedge clk);
        end while (!(pd === 1'b1 && per > hi));
    endtask
    task finish_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 25000)
        begin
            n_fail++;
            finish_test;
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk({4'h0, a_am}, 32'h0000_0001);
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
        rd_chk(`VCS_OFF_CALTIME, 32'h0000_8401);
        rd_chk(8'h20, 32'h0000_0000);
        xfer(`VCS_OFF_CALTIME, 1'b1, 32'hFFFF_FFFF);
        rd_chk(`VCS_OFF_CALTIME, 32'h000F_FFFF);
        for (int i = 0; i < 4; i++)
        begin
            xfer(`VCS_OFF_REFCTL, 1'b1, refv[i]);
            meas;
            meas;
            chk(per, ep[i]);
            chk(hi, eh[i]);
        end
        xfer(`VCS_OFF_REFCTL, 1'b1, 32'h0000_0004);
        // detector at 12.5 MHz: settling 20 us, band clock below 100 kHz
        xfer(`VCS_OFF_CALTIME, 1'b1, 32'h0000_E40A);
        xfer(`VCS_OFF_BANDDIV, 1'b1, 32'h0000_0008);
        xfer(`VCS_OFF_PFRAC, 1'b1, 32'h0000_0123);
        xfer(`VCS_OFF_AFRAC, 1'b1, 32'h0000_0400);
        xfer(`VCS_OFF_AMOD, 1'b1, 32'h0000_0600);
        chk({8'h00, a_pf}, 32'h0000_0000);
        chk({4'h0, a_af}, 32'h0000_0000);
        chk({4'h0, a_am}, 32'h0000_0001);
        xfer(`VCS_OFF_INTEGER, 1'b1, 32'h0000_0005);
        n0 = 0;
        n1 = 0;
        n2 = 0;
        n3 = 0;
        for (int k = 0; k < 20000; k++)
        begin
            @(negedge clk);
            if (busy !== 1'b1)
                break;
            n0 += (dacf === 1'b1 && pd === 1'b1);
            n1 += (bclk === 1'b1);
            n2 += (lact === 1'b1 && pd === 1'b1);
            n3 += (bact === 1'b1 && pd === 1'b1);
        end
        chk(n0, 250);
        chk(n1, 11);
        chk(n3, 1408);
        chk(n2, 300);
        chk({16'h0000, a_int}, 32'h0000_0005);
        chk({8'h00, a_pf}, 32'h0000_0123);
        chk({4'h0, a_af}, 32'h0000_0400);
        chk({4'h0, a_am}, 32'h0000_0600);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk({16'h0000, a_int}, 32'h0000_0000);
        chk({4'h0, a_am}, 32'h0000_0001);
        chk({31'h0000_0000, busy}, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        rd_chk(`VCS_OFF_CALTIME, 32'h0000_8401);
        finish_test;
    end
endmodule
